/* File: src/sfs_pin_sync.v */
/*
 * two-flop synchroniser for the four serial pins of the status block.
 * assumes all inputs are asynchronous to mclk; output is the second flop.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfs_status_regs.vh"

module sfs_pin_sync (
	// clock and reset
	input wire mclk,
	input wire srst,
	// raw pins in, resolved levels out
	input wire [`SFS_SYNC_W-1:0] pin_in,
	output wire [`SFS_SYNC_W-1:0] pin_out
);

	reg [`SFS_SYNC_W-1:0] meta_r;
	reg [`SFS_SYNC_W-1:0] stab_r;

	// first flop feeds only the second; idle pins read high after reset
	always @(posedge mclk) begin
		if (srst) begin
			meta_r <= {`SFS_SYNC_W{1'b1}};
			stab_r <= {`SFS_SYNC_W{1'b1}};
		end else begin
			meta_r <= pin_in;
			stab_r <= meta_r;
		end
	end

	assign pin_out = stab_r;

endmodule

`default_nettype wire

/* File: src/sfs_status_core.v */
/*
 * two-byte status register of a serial flash, with its serial command
 * front end (read status, write byte one, write byte two, write enable,
 * write disable, software reset). sclk, cs_n, si and wp_n are pins and are
 * sampled by mclk, which must run well above four times the sclk rate.
 * the array core supplies busy, suspend, protection summary and the
 * outcome of each erase or program, and obeys the lock and enables.
 */
// Summary of operation
// R01 - read-status opcode then status bits every clock
// R02 - bytes alternate one, two, one while selected
// R03 - content sampled live; busy at bit zero
// R04 - fast clocks: host reads four bytes minimum
// R05 - chip select high ends read, output floats
// R06 - byte one: lock, zero, error, pin, summary
// R07 - byte two: zeros, enables, suspends, busy
// R08 - byte one write changes only lock bit
// R09 - byte two write changes only bits four, three
// R10 - lock set blocks protect, unprotect, global
// R11 - lock clears at power-up, kept by reset
// R12 - pin asserted: lock may only be set
// R13 - failed byte in erase/program sets error
// R14 - aborted erase/program never sets error; op_done with op_failed in the same cycle still sets it
// R15 - error re-evaluated after every erase/program
// R16 - pin status bit mirrors write-protect level
// R17 - status readable any time, even busy
// R18 - write latch clears at reset, write-class end
// R19 - reset command ignored unless enabled
// R20 - msb first, changes on falling clock
`timescale 1ns/1ps
`default_nettype none
`include "sfs_status_regs.vh"

module sfs_status_core (
	// clock and power-up reset
	input wire mclk,
	input wire srst,
	// serial pins
	input wire sclk,
	input wire cs_n,
	input wire si,
	output reg so,
	output reg so_oe_n,
	// write-protect pin, active low
	input wire wp_n,
	// array core status inputs, mclk domain
	input wire busy_flag,
	input wire [1:0] soft_protect_summary,
	input wire program_suspended,
	input wire erase_suspended,
	input wire lockdown_frozen,
	input wire op_done,
	input wire op_failed,
	input wire op_aborted,
	input wire wel_clear,
	// controls to the array core
	output reg protection_lock,
	output reg write_enable_latch,
	output reg reset_cmd_enable,
	output reg lockdown_cmd_enable,
	output reg program_erase_error,
	output reg soft_reset,
	output reg global_req,
	output reg [3:0] global_code
);

	localparam [4:0] ST_OPC = 5'h01;
	localparam [4:0] ST_RDSR = 5'h02;
	localparam [4:0] ST_WR1 = 5'h04;
	localparam [4:0] ST_WR2 = 5'h08;
	localparam [4:0] ST_HOLD = 5'h10;

	wire [`SFS_SYNC_W-1:0] pins_s;
	wire sclk_s;
	wire cs_n_s;
	wire si_s;
	wire wp_n_s;
	reg sclk_d_r;
	reg cs_n_d_r;
	reg [4:0] state_r;
	reg [2:0] bit_cnt_r;
	reg [6:0] in_sh_r;
	reg [7:0] op_r;
	reg [7:0] data_r;
	reg got_byte_r;
	reg [2:0] out_cnt_r;
	reg [6:0] out_sh_r;
	reg byte_sel_r;
	wire sclk_rise;
	wire sclk_fall;
	wire cs_rise;
	wire cs_fall;
	wire [7:0] in_byte;
	wire [7:0] stat_one;
	wire [7:0] stat_two;
	wire [7:0] cur_byte;
	wire commit;

	// all four pins come from off-chip
	sfs_pin_sync u_sync (
		.mclk(mclk),
		.srst(srst),
		.pin_in({sclk, cs_n, si, wp_n}),
		.pin_out(pins_s)
	);

	assign sclk_s = pins_s[3];
	assign cs_n_s = pins_s[2];
	assign si_s = pins_s[1];
	assign wp_n_s = pins_s[0];

	// edge history of the resolved sclk and cs_n pins
	always @(posedge mclk) begin
		if (srst) begin
			sclk_d_r <= 1'b1;
			cs_n_d_r <= 1'b1;
		end else begin
			sclk_d_r <= sclk_s;
			cs_n_d_r <= cs_n_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
	assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;
	assign cs_rise = cs_n_s & ~cs_n_d_r;
	assign cs_fall = ~cs_n_s & cs_n_d_r;
	assign in_byte = {in_sh_r, si_s};

	// R06 byte one layout
	// R16 pin level mirrored
	assign stat_one = {protection_lock, 1'b0, program_erase_error, wp_n_s,
		soft_protect_summary, write_enable_latch, busy_flag};
	// R07 byte two layout
	assign stat_two = {3'h0, reset_cmd_enable, lockdown_cmd_enable,
		program_suspended, erase_suspended, busy_flag};
	// R02 alternate the two bytes
	assign cur_byte = byte_sel_r ? stat_two : stat_one;

	// a data write only counts on a whole byte and a byte boundary
	assign commit = cs_rise & got_byte_r & (bit_cnt_r == 3'h0);

	// input shifter and opcode decoding on rising sclk
	always @(posedge mclk) begin
		if (srst) begin
			state_r <= ST_OPC;
			bit_cnt_r <= 3'h0;
			in_sh_r <= 7'h00;
			op_r <= 8'h00;
			data_r <= 8'h00;
			got_byte_r <= 1'b0;
		end else if (cs_n_s | cs_fall) begin
			// deselect restarts decoding on the next frame
			state_r <= ST_OPC;
			bit_cnt_r <= 3'h0;
			got_byte_r <= 1'b0;
			if (cs_fall)
				op_r <= 8'h00;
		end else if (sclk_rise) begin
			in_sh_r <= in_byte[6:0];
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == `SFS_BIT_LAST) begin
				case (state_r)
				ST_OPC: begin
					op_r <= in_byte;
					// R01 opcode selects the status read
					// R17 no busy gating on the read
					if (in_byte == `SFS_OP_READ_STATUS)
						state_r <= ST_RDSR;
					else if (in_byte == `SFS_OP_WRITE_STAT1)
						state_r <= ST_WR1;
					else if (in_byte == `SFS_OP_WRITE_STAT2)
						state_r <= ST_WR2;
					else
						state_r <= ST_HOLD;
				end
				ST_WR1, ST_WR2: begin
					// later bytes are ignored
					if (!got_byte_r)
						data_r <= in_byte;
					got_byte_r <= 1'b1;
				end
				ST_RDSR, ST_HOLD: begin
					state_r <= state_r;
				end
				default: begin
					state_r <= ST_OPC;
				end
				endcase
			end
		end
	end

	// status output shifter on falling sclk
	always @(posedge mclk) begin
		if (srst) begin
			so <= 1'b0;
			so_oe_n <= 1'b1;
			out_cnt_r <= 3'h0;
			out_sh_r <= 7'h00;
			byte_sel_r <= 1'b0;
		end else if (cs_n_s || state_r != ST_RDSR) begin
			// R05 deselect floats the output at once
			so_oe_n <= 1'b1;
			out_cnt_r <= 3'h0;
			byte_sel_r <= 1'b0;
		end else if (sclk_fall) begin
			so_oe_n <= 1'b0;
			if (out_cnt_r == 3'h0) begin
				// R03 fresh snapshot per byte
				// R20 msb first on falling edge
				so <= cur_byte[7];
				out_sh_r <= cur_byte[6:0];
				byte_sel_r <= ~byte_sel_r;
			end else begin
				so <= out_sh_r[6];
				out_sh_r <= {out_sh_r[5:0], 1'b0};
			end
			out_cnt_r <= out_cnt_r + 3'h1;
		end
	end

	// command effects at deselect, plus array core feedback
	always @(posedge mclk) begin
		if (srst) begin
			// R11 lock clear at power-up
			protection_lock <= `SFS_RST_LOCK;
			// R18 latch clear at power-up
			write_enable_latch <= `SFS_RST_WEL;
			reset_cmd_enable <= `SFS_RST_RESET_CMD_ENABLE;
			lockdown_cmd_enable <= `SFS_RST_SLE;
			program_erase_error <= `SFS_RST_ERR;
			soft_reset <= 1'b0;
			global_req <= 1'b0;
			global_code <= 4'h0;
		end else begin
			soft_reset <= 1'b0;
			global_req <= 1'b0;
			// frozen lockdown holds the enable off while it is asserted
			if (lockdown_frozen)
				lockdown_cmd_enable <= 1'b0;
			// R13 failure sets the flag
			// R15 every completion re-evaluates
			if (op_done)
				program_erase_error <= op_failed;
			// R14 abort clears it when op_done is not in the same cycle
			else if (op_aborted)
				program_erase_error <= 1'b0;
			// R18 write-class command ended in the core
			if (wel_clear)
				write_enable_latch <= 1'b0;
			if (cs_rise) begin
				case (state_r)
				ST_WR1: begin
					// R18 cleared whether done or aborted
					write_enable_latch <= 1'b0;
					// R12 pin asserted refuses a clear
					// R08 only the lock bit is written
					if (commit && write_enable_latch &&
						!(!wp_n_s && protection_lock && !data_r[`SFS_B1_LOCK])) begin
						protection_lock <= data_r[`SFS_B1_LOCK];
						// R10 global change only from unlocked
						if (!protection_lock) begin
							global_req <= 1'b1;
							global_code <= data_r[`SFS_GP_HI:`SFS_GP_LO];
						end
					end
				end
				ST_WR2: begin
					write_enable_latch <= 1'b0;
					// R09 only the two enables
					if (commit && write_enable_latch) begin
						reset_cmd_enable <= data_r[`SFS_B2_RESET_CMD_ENABLE];
						if (!lockdown_frozen)
							lockdown_cmd_enable <= data_r[`SFS_B2_SLE];
					end
				end
				ST_HOLD: begin
					if (bit_cnt_r == 3'h0) begin
						if (op_r == `SFS_OP_WRITE_EN)
							write_enable_latch <= 1'b1;
						else if (op_r == `SFS_OP_WRITE_DIS)
							write_enable_latch <= 1'b0;
						// R19 reset only when enabled
						// R11 lock and enables survive it
						else if (op_r == `SFS_OP_SOFT_RESET && reset_cmd_enable) begin
							soft_reset <= 1'b1;
							write_enable_latch <= 1'b0;
						end
					end
				end
				ST_OPC, ST_RDSR: begin
					soft_reset <= 1'b0;
				end
				default: begin
					soft_reset <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* File: src/sfs_status_regs.vh */
/*
 * constants of the serial flash status register block: command codes,
 * bit positions of both status bytes and reset values.
 * assumes it is included by bare name from files under src/.
 */
`ifndef SFS_STATUS_REGS_VH
`define SFS_STATUS_REGS_VH

// command codes
`define SFS_OP_READ_STATUS 8'h05
`define SFS_OP_WRITE_STAT1 8'h01
`define SFS_OP_WRITE_STAT2 8'h31
`define SFS_OP_WRITE_EN 8'h06
`define SFS_OP_WRITE_DIS 8'h04
`define SFS_OP_SOFT_RESET 8'hf0

// status byte one fields
`define SFS_B1_LOCK 7
`define SFS_B1_RSVD 6
`define SFS_B1_ERR 5
`define SFS_B1_WPPIN 4
`define SFS_B1_SWP_HI 3
`define SFS_B1_SWP_LO 2
`define SFS_B1_WEL 1
`define SFS_B1_BUSY 0

// status byte two fields
`define SFS_B2_RESET_CMD_ENABLE 4
`define SFS_B2_SLE 3
`define SFS_B2_PSUSP 2
`define SFS_B2_ESUSP 1
`define SFS_B2_BUSY 0

// global protect code field within the byte one write
`define SFS_GP_HI 5
`define SFS_GP_LO 2

// reset values
`define SFS_RST_LOCK 1'b0
`define SFS_RST_WEL 1'b0
`define SFS_RST_RESET_CMD_ENABLE 1'b0
`define SFS_RST_SLE 1'b0
`define SFS_RST_ERR 1'b0

// pin synchroniser width and bit counter top
`define SFS_SYNC_W 4
`define SFS_BIT_LAST 3'h7

`endif

/* File: verification/sfs_spi_host.sv */
/* behavioural serial host, mode 0, 125 ns link clock.
   assumes one frame at a time through xfer. */
`timescale 1ns/1ps
`default_nettype none
module sfs_spi_host (
	// link pins driven
	output var logic sclk = 1'b0,
	output var logic cs_n = 1'b1,
	output var logic si = 1'b0,
	// device answer
	input wire so,
	input wire so_oe_n
);
	task xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
		rx = '0;
		cs_n = 0;
		#200;
		// clock runs only inside the frame
		for (int i = n - 1; i >= 0; i--) begin
			si = tx[i];
			#62.5 sclk = 1;
			rx[i] = so_oe_n ? 1'bz : so;
			#62.5 sclk = 0;
		end
		#100 cs_n = 1;
		si = ~si; // inverted line, no stale level
		#300;
	endtask
endmodule
`default_nettype wire

/* File: verification/sfs_status_core_props.sv */
/* checker for the status core ports, sampled on mclk; cs_n and wp_n are the raw pins.
   assumes the bind below, with pins changing well away from reset. */
`timescale 1ns/1ps
`default_nettype none
module sfs_props (
	// clock, reset, pins
	input wire mclk,
	input wire srst,
	input wire cs_n,
	input wire wp_n,
	input wire so_oe_n,
	// core feedback
	input wire op_done,
	input wire op_failed,
	input wire op_aborted,
	input wire wel_clear,
	input wire lockdown_frozen,
	// register outputs
	input wire protection_lock,
	input wire write_enable_latch,
	input wire reset_cmd_enable,
	input wire lockdown_cmd_enable,
	input wire program_erase_error,
	input wire soft_reset,
	input wire global_req
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_cs_rise; !cs_n ##1 cs_n; endsequence
	// error flag follows only the latest operation
	property p_err_done; op_done |=> program_erase_error == $past(op_failed); endproperty
	a_err_done: assert property (p_err_done) else $error("error flag bad");
	property p_err_abort; op_aborted && !op_done |=> !program_erase_error; endproperty
	a_err_abort: assert property (p_err_abort) else $error("abort set error");
	// latch, lock and enables
	property p_wl_clr; wel_clear |=> !write_enable_latch; endproperty
	a_wl_clr: assert property (p_wl_clr) else $error("latch kept");
	property p_rst;
		disable iff (1'b0) srst |=> !protection_lock && !write_enable_latch
			&& !reset_cmd_enable && !program_erase_error && !soft_reset;
	endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_sreset; soft_reset |-> reset_cmd_enable ##1
		$stable(protection_lock) && $stable(reset_cmd_enable); endproperty
	a_sreset: assert property (p_sreset) else $error("soft reset");
	property p_frozen; lockdown_frozen |=> !lockdown_cmd_enable; endproperty
	a_frozen: assert property (p_frozen) else $error("frozen enable");
	property p_lock_wp; $fell(protection_lock) |-> wp_n; endproperty
	a_lock_wp: assert property (p_lock_wp) else $error("lock cleared");
	// lock depth two covers either update timing
	property p_glob; global_req |-> !$past(protection_lock, 2); endproperty
	a_glob: assert property (p_glob) else $error("global while locked");
	property p_float; s_cs_rise |-> ##[1:6] so_oe_n; endproperty
	a_float: assert property (p_float) else $error("output kept");
endmodule
bind sfs_status_core sfs_props u_props (.mclk, .srst, .cs_n, .wp_n, .so_oe_n, .op_done,
	.op_failed, .op_aborted, .wel_clear, .lockdown_frozen, .protection_lock,
	.write_enable_latch, .reset_cmd_enable, .lockdown_cmd_enable, .program_erase_error,
	.soft_reset, .global_req);
`default_nettype wire

/* File: verification/test_sfs_status_core.sv */
/* bench for the status core: host model on the pins, core side here.
   assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module test_sfs_status_core;
	logic mclk = 0, srst = 1, wp_n = 1, busy = 1, psusp = 0, esusp = 0, frz = 0;
	logic done = 0, fail = 0, abrt = 0, wclr = 0;
	logic [1:0] prot_sum = 2'h3;
	logic [39:0] rx;
	wire sclk, cs_n, si, so, so_oe_n, lock, wlatch, rst_en, ldn_en, err, srp, greq;
	wire [3:0] gcode;
	int failures = 0, cmp_count = 0, cyc = 0, resets = 0, globals = 0;
	always #4 mclk = ~mclk;
	sfs_spi_host u_host (.sclk, .cs_n, .si, .so, .so_oe_n);
	sfs_status_core u_dut (.mclk, .srst, .sclk, .cs_n, .si, .so, .so_oe_n, .wp_n,
		.busy_flag(busy), .soft_protect_summary(prot_sum), .program_suspended(psusp),
		.erase_suspended(esusp), .lockdown_frozen(frz), .op_done(done), .op_failed(fail),
		.op_aborted(abrt), .wel_clear(wclr), .protection_lock(lock),
		.write_enable_latch(wlatch), .reset_cmd_enable(rst_en), .lockdown_cmd_enable(ldn_en),
		.program_erase_error(err), .soft_reset(srp), .global_req(greq), .global_code(gcode));
	task check(input logic [39:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// four bytes, so the later pair is valid too
	task rd(input logic [31:0] exp);
		u_host.xfer({8'h05, 32'h0}, 40, rx);
		check(rx[31:0], exp);
	endtask
	// hang guard and soft reset count
	always @(posedge mclk) begin
		cyc++;
		if (srp === 1'b1) resets++;
		if (greq === 1'b1) globals++;
		if (cyc == 50000) begin
			failures++;
			stop_test;
		end
	end
	initial begin
		tick(12);
		srst = 0;
		tick(4);
		rd(32'h1d011d01);
		// deselect mid-byte ends the read and floats the output
		u_host.xfer(40'h050, 12, rx);
		check({so_oe_n, rx[3:0]}, 5'h11);
		wp_n = 0; busy = 0; psusp = 1; esusp = 1; prot_sum = 2'h1;
		tick(4);
		rd(32'h04060406);
		// pin asserted: set allowed, clear refused
		u_host.xfer(40'h06, 8, rx);
		u_host.xfer(40'h01ff, 16, rx);
		rd(32'h84068406);
		// unlocked write passes bits five to two on as one request
		check({globals[3:0], gcode}, 8'h1f);
		u_host.xfer(40'h06, 8, rx);
		u_host.xfer(40'h0100, 16, rx);
		tick(2);
		check({lock, wlatch}, 2'h2);
		wp_n = 1;
		u_host.xfer(40'h06, 8, rx);
		u_host.xfer(40'h0100, 16, rx);
		tick(2);
		check(lock, 0);
		// lock was set before both later writes: no global request
		check(globals, 1);
		// no latch, no byte two write; reset ignored while disabled
		u_host.xfer(40'h31ff, 16, rx);
		u_host.xfer(40'hf0, 8, rx);
		check(resets, 0);
		u_host.xfer(40'h06, 8, rx);
		u_host.xfer(40'h31ff, 16, rx);
		rd(32'h141e141e);
		u_host.xfer(40'hf0, 8, rx);
		check({resets[3:0], rst_en}, 5'h3);
		frz = 1;
		tick(2);
		frz = 0;
		// error flag, then abort
		done = 1; fail = 1;
		tick(1);
		done = 0;
		tick(1);
		check(err, 1);
		abrt = 1;
		tick(1);
		abrt = 0;
		tick(1);
		check(err, 0);
		u_host.xfer(40'h06, 8, rx);
		check(wlatch, 1);
		wclr = 1;
		tick(1);
		wclr = 0;
		tick(1);
		check(wlatch, 0);
		stop_test;
	end
endmodule
`default_nettype wire
